// File: verilog/gcl_pkg.sv
/*
 * gcl_pkg: constants, register map, field positions and timing counts of the
 * three-phase gate control logic.
 * Assumes a 250 MHz system clock and a 32-bit APB register bus.
 */
`default_nettype none
package gcl_pkg;
  // ==========================================================================
  // timing
  localparam int unsigned CLK_NS      = 4;
  localparam int unsigned DT_STEP_NS  = 50;
  localparam int unsigned DT_MAX_NS   = 12000;
  localparam int unsigned DT_STEP_CYC = (DT_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DT_SET_MAXV = DT_MAX_NS / DT_STEP_NS;
  localparam int unsigned FILT_NS     = 1000;
  localparam int unsigned FILT_CYC    = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BLANK_NS    = 400;
  localparam int unsigned BLANK_CYC   = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================================
  // widths
  localparam int ADDR_W   = 12;
  localparam int SET_W    = 8;
  localparam int CAL_W    = 5;
  localparam int DT_CNT_W = SET_W + CAL_W;
  localparam int FILT_W   = 8;
  localparam int BLANK_W  = 7;
  localparam int CTRL_W   = 4;
  localparam int NPH      = 3;
  // ==========================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_DT   = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_CAL  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_ST0  = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_ST1  = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_CMD  = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_SIM  = 12'h01C;
  // ==========================================================================
  // fields, codes and reset values
  localparam int CTRL_FULL_ON = 0;
  localparam int CTRL_NO_SD   = 1;
  localparam int CTRL_ZERO_DT = 2;
  localparam int CTRL_LOCK    = 3;
  localparam int ST_OC        = 0;
  localparam int ST_DESAT     = 1;
  localparam int ST_PHASE     = 2;
  localparam int ST1_SD       = 9;
  localparam int ST1_SIM      = 10;
  localparam int ST1_SIM_USED = 11;
  localparam int ST1_EN       = 12;
  localparam logic [7:0]        CMD_CLR0    = 8'h01;
  localparam logic [7:0]        CMD_CLR1    = 8'h02;
  localparam logic [7:0]        CMD_KEY_A   = 8'hA5;
  localparam logic [7:0]        CMD_KEY_B   = 8'h5A;
  localparam logic [CTRL_W-1:0] CTRL_RST    = 4'h0;
  localparam logic [SET_W-1:0]  DT_SET_RST  = 8'h00;
  localparam logic [SET_W-1:0]  DT_SET_MAX  = SET_W'(DT_SET_MAXV);
  localparam logic [CAL_W-1:0]  CAL_RST     = CAL_W'(DT_STEP_CYC);
  localparam logic [2:0]        MASK_RST    = 3'h0;
  // ==========================================================================
  // guard sequence for the simultaneous conduction command
  typedef enum logic [1:0] {GD_IDLE, GD_KEY_A, GD_OPEN} gcl_guard_e;
endpackage : gcl_pkg
`default_nettype wire

// File: verilog/gcl_desat_filter.sv
/*
 * gcl_desat_filter: digital filter on one started desaturation condition.
 * Assumes the condition input is synchronous to clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module gcl_desat_filter #(
  parameter int unsigned CYC = gcl_pkg::FILT_CYC,
  parameter int          W   = gcl_pkg::FILT_W
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // condition and result
  input  wire logic cond_i,
  output var  logic fault_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         fault;
  } gcl_filt_s;

  gcl_filt_s q;
  gcl_filt_s d;

  // ==========================================================================
  // filter counter
  always_comb begin : filt_next
    d = q;
    if (!cond_i) begin
      d.cnt = '0; // RULE19
    end else if (q.cnt != W'(CYC)) begin
      d.cnt = q.cnt + 1'b1;
    end
    d.fault = cond_i && (d.cnt == W'(CYC)); // RULE18
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin : filt_reg
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fault_o = q.fault;
endmodule : gcl_desat_filter
`default_nettype wire

// File: verilog/gcl_phase.sv
/*
 * gcl_phase: one phase of edge-sensitive gate control with deadtime,
 * bootstrap start-up interlock, blanking and fault sampling.
 * Assumes command and comparator inputs synchronous to clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module gcl_phase #(
  parameter int unsigned BLANK_CYC = gcl_pkg::BLANK_CYC
) (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  // configuration
  input  wire logic                          enable_i,
  input  wire logic                          sim_en_i,
  input  wire logic                          full_on_i,
  input  wire logic [gcl_pkg::DT_CNT_W-1:0]  dt_cycles_i,
  // commands and comparators
  input  wire logic                          hs_cmd_i,
  input  wire logic                          ls_cmd_i,
  input  wire logic                          desat_cmp_i,
  input  wire logic                          phase_cmp_i,
  // gates and flags
  output var  logic                          hs_gate_o,
  output var  logic                          ls_gate_o,
  output var  logic                          blank_o,
  output var  logic                          desat_o,
  output var  logic                          hs_err_o,
  output var  logic                          ls_err_o
);
  typedef struct packed {
    logic                         hs_prev;
    logic                         ls_prev;
    logic                         hs_gate;
    logic                         ls_gate;
    logic                         hs_pend;
    logic                         ls_pend;
    logic                         ls_seen;
    logic [gcl_pkg::DT_CNT_W-1:0] dead;
    logic [gcl_pkg::BLANK_W-1:0]  blank;
    logic                         blank_act;
    logic                         desat;
    logic                         hs_err;
    logic                         ls_err;
  } gcl_phase_s;

  gcl_phase_s q;
  gcl_phase_s d;
  logic       hs_rise;
  logic       hs_fall;
  logic       ls_rise;
  logic       ls_fall;
  logic       checked;

  // ==========================================================================
  // next state
  always_comb begin : phase_next
    d       = q;
    hs_rise = hs_cmd_i & ~q.hs_prev;
    hs_fall = ~hs_cmd_i & q.hs_prev;
    ls_rise = ls_cmd_i & ~q.ls_prev;
    ls_fall = ~ls_cmd_i & q.ls_prev;
    checked = (q.blank == '0);
    d.hs_prev = hs_cmd_i;
    d.ls_prev = ls_cmd_i;
    if (q.dead != '0) begin
      d.dead = q.dead - 1'b1;
    end
    if (q.blank != '0) begin
      d.blank = q.blank - 1'b1;
    end
    if ((hs_rise | hs_fall | ls_rise | ls_fall) && !sim_en_i) begin
      d.blank = gcl_pkg::BLANK_W'(BLANK_CYC); // RULE12 RULE3
    end
    if (hs_rise) begin
      d.hs_pend = 1'b1;
      if (!sim_en_i) begin
        d.ls_pend = 1'b0;
        if (q.ls_gate) begin
          d.ls_gate = 1'b0; // RULE8
          d.dead    = dt_cycles_i; // RULE9
        end
      end
    end
    if (ls_rise) begin
      d.ls_pend = 1'b1;
      if (!sim_en_i) begin
        d.hs_pend = 1'b0;
        if (q.hs_gate) begin
          d.hs_gate = 1'b0; // RULE8
          d.dead    = dt_cycles_i; // RULE9
        end
      end
    end
    if (hs_fall) begin
      d.hs_pend = 1'b0;
      if (q.hs_gate) begin
        d.hs_gate = 1'b0;
        d.dead    = dt_cycles_i; // RULE9
      end
    end
    if (ls_fall) begin
      d.ls_pend = 1'b0;
      if (q.ls_gate) begin
        d.ls_gate = 1'b0;
        d.dead    = dt_cycles_i; // RULE9
      end
    end
    // turn on once the deadtime is over, at once if it already is
    if (q.hs_pend && d.hs_pend && !q.hs_gate && (q.ls_seen || full_on_i) &&
        (sim_en_i || (q.dead == '0 && !q.ls_gate && !d.ls_gate))) begin
      d.hs_gate = 1'b1; // RULE9 RULE10 RULE11
    end
    if (q.ls_pend && d.ls_pend && !q.ls_gate &&
        (sim_en_i || (q.dead == '0 && !q.hs_gate && !d.hs_gate))) begin
      d.ls_gate = 1'b1; // RULE9 RULE10
      d.ls_seen = 1'b1; // RULE11
    end
    if ((d.hs_gate && !q.hs_gate) || (d.ls_gate && !q.ls_gate)) begin
      if (!sim_en_i) begin
        d.blank = gcl_pkg::BLANK_W'(BLANK_CYC); // RULE3
      end
    end
    if (!enable_i) begin
      d.hs_gate = 1'b0; // RULE23
      d.ls_gate = 1'b0;
      d.hs_pend = 1'b0;
      d.ls_pend = 1'b0;
      d.ls_seen = 1'b0; // RULE11
    end
    d.blank_act = (d.blank != '0);
    // fault sampling after the blanking time
    d.desat  = q.hs_gate && checked && desat_cmp_i; // RULE17
    d.hs_err = q.hs_gate && checked && !phase_cmp_i;
    d.ls_err = q.ls_gate && checked && phase_cmp_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin : phase_reg
    if (!rst_n_i) begin
      q <= '0; // RULE22
    end else begin
      q <= d;
    end
  end

  assign hs_gate_o = q.hs_gate;
  assign ls_gate_o = q.ls_gate;
  assign blank_o   = q.blank_act;
  assign desat_o   = q.desat;
  assign hs_err_o  = q.hs_err;
  assign ls_err_o  = q.ls_err;
endmodule : gcl_phase
`default_nettype wire

// File: verilog/gcl_top.sv
/*
 * gcl_top: three-phase gate control logic with APB register slave,
 * fault latching, protective shutdown and interrupt output.
 * Assumes all pins synchronous to clk_i (250 MHz) and an APB master.
 */
// Overview of operation
// RULE1 - deadtime programmable over the bus in 50 ns steps, 0 to 12 us
// RULE2 - host calibrates the deadtime step through a bus register
// RULE3 - simultaneous conduction mode turns blanking off; otherwise never both on
// RULE4 - simultaneous mode accepted once per reset, after a two-key guard sequence
// RULE5 - full-on, desaturation behaviour and zero deadtime set and lockable by software
// RULE6 - software chooses which faults are reported and enables interrupt sources
// RULE7 - status registers readable by the bus master
// RULE8 - command leading edge turns complementary gate off, selected on after deadtime
// RULE9 - deadtime starts at each turn-off and blocks the complementary turn-on; the code loads none when enable low forces the gates off
// RULE10 - turn-on after the deadtime already elapsed acts at once
// RULE11 - high side refused after enable until its low side was on once
// RULE12 - low-side current limit blanked briefly after each input change
// RULE13 - overcurrent comparator drives the indicator output and latches a fault
// RULE14 - latched overcurrent shows in status register zero
// RULE15 - masked-in overcurrent fault raises the interrupt output
// RULE16 - interrupt held until fault gone and cleared by group-zero clear
// RULE17 - high side on after blanking with source node low starts desaturation
// RULE18 - desaturation filtered 1.0 us, then all gates off
// RULE19 - desaturation that clears before the filter ends is dropped
// RULE20 - desaturation and phase faults recorded in the fault status register
// RULE21 - software masks interrupts and disables fault shutdown
// RULE22 - reset low clears every register and switches all gates off; the cal register resets to DT_STEP_CYC instead
// RULE23 - gates run only while both enables and reset are high
// RULE24 - phase error flag ORs all phase errors, cleared by group-one clear
// RULE25 - deadtime counter loads setting times calibrated step cycles
// RULE26 - a latched fault holds until absent and its clear command arrives
`timescale 1ns/10ps
`default_nettype none
module gcl_top (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // apb slave
  input  wire logic [gcl_pkg::ADDR_W-1:0]  paddr_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [31:0]                 pwdata_i,
  output var  logic [31:0]                 prdata_o,
  output var  logic                        pready_o,
  output var  logic                        pslverr_o,
  // enables
  input  wire logic                        enable_input_one_i,
  input  wire logic                        enable_input_two_i,
  // phase commands
  input  wire logic [gcl_pkg::NPH-1:0]     high_side_command_input_i,
  input  wire logic [gcl_pkg::NPH-1:0]     low_side_command_input_i,
  // comparators
  input  wire logic [gcl_pkg::NPH-1:0]     high_side_source_node_desat_i,
  input  wire logic [gcl_pkg::NPH-1:0]     high_side_source_node_phase_i,
  input  wire logic                        overcurrent_cmp_i,
  // gate drive and indicators
  output var  logic [gcl_pkg::NPH-1:0]     high_side_gate_output_o,
  output var  logic [gcl_pkg::NPH-1:0]     low_side_gate_output_o,
  output var  logic [gcl_pkg::NPH-1:0]     current_limit_blank_o,
  output var  logic                        overcurrent_indicator_output_o,
  output var  logic                        int_o
);
  typedef struct packed {
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    prdata;
    logic [gcl_pkg::CTRL_W-1:0]     ctrl;
    logic [gcl_pkg::SET_W-1:0]      dt_set;
    logic [gcl_pkg::CAL_W-1:0]      cal;
    logic [2:0]                     mask;
    logic                           sim_en;
    logic                           sim_used;
    gcl_pkg::gcl_guard_e            guard;
    logic                           oc_ind;
    logic                           oc_flag;
    logic [gcl_pkg::NPH-1:0]        desat_flag;
    logic [gcl_pkg::NPH-1:0]        hs_err_flag;
    logic [gcl_pkg::NPH-1:0]        ls_err_flag;
    logic                           shutdown;
    logic                           en;
    logic                           irq;
  } gcl_top_s;

  gcl_top_s                       q;
  gcl_top_s                       d;
  logic [gcl_pkg::DT_CNT_W-1:0]   dt_cycles;
  logic [gcl_pkg::NPH-1:0]        desat_start;
  logic [gcl_pkg::NPH-1:0]        desat_fault;
  logic [gcl_pkg::NPH-1:0]        hs_err;
  logic [gcl_pkg::NPH-1:0]        ls_err;
  logic [31:0]                    rd_data;
  logic                           rd_hit;
  logic                           setup;
  logic                           wr_acc;
  logic                           clr0;
  logic                           clr1;
  logic [2:0]                     st0;
  logic                           phase_any;

  // ==========================================================================
  // deadtime in clock cycles
  always_comb begin : dt_calc
    if (q.ctrl[gcl_pkg::CTRL_ZERO_DT]) begin
      dt_cycles = '0; // RULE5
    end else begin
      dt_cycles = {{gcl_pkg::CAL_W{1'b0}}, q.dt_set} *
                  {{gcl_pkg::SET_W{1'b0}}, q.cal}; // RULE25 RULE1 RULE2
    end
  end

  // ==========================================================================
  // phases
  genvar gi;
  generate
    for (gi = 0; gi < gcl_pkg::NPH; gi++) begin : g_phase
      gcl_phase u_phase (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .enable_i    (q.en),
        .sim_en_i    (q.sim_en),
        .full_on_i   (q.ctrl[gcl_pkg::CTRL_FULL_ON]),
        .dt_cycles_i (dt_cycles),
        .hs_cmd_i    (high_side_command_input_i[gi]),
        .ls_cmd_i    (low_side_command_input_i[gi]),
        .desat_cmp_i (high_side_source_node_desat_i[gi]),
        .phase_cmp_i (high_side_source_node_phase_i[gi]),
        .hs_gate_o   (high_side_gate_output_o[gi]),
        .ls_gate_o   (low_side_gate_output_o[gi]),
        .blank_o     (current_limit_blank_o[gi]),
        .desat_o     (desat_start[gi]),
        .hs_err_o    (hs_err[gi]),
        .ls_err_o    (ls_err[gi])
      );
      gcl_desat_filter u_filt (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .cond_i  (desat_start[gi]),
        .fault_o (desat_fault[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // register read decode
  always_comb begin : rd_decode
    phase_any = |{q.hs_err_flag, q.ls_err_flag}; // RULE24
    st0       = {phase_any, |q.desat_flag, q.oc_flag};
    rd_data   = '0;
    rd_hit    = 1'b1;
    if (paddr_i == gcl_pkg::ADDR_CTRL) begin
      rd_data[gcl_pkg::CTRL_W-1:0] = q.ctrl;
    end else if (paddr_i == gcl_pkg::ADDR_DT) begin
      rd_data[gcl_pkg::SET_W-1:0] = q.dt_set;
    end else if (paddr_i == gcl_pkg::ADDR_CAL) begin
      rd_data[gcl_pkg::CAL_W-1:0] = q.cal;
    end else if (paddr_i == gcl_pkg::ADDR_MASK) begin
      rd_data[2:0] = q.mask;
    end else if (paddr_i == gcl_pkg::ADDR_ST0) begin
      rd_data[2:0] = st0; // RULE7 RULE14
    end else if (paddr_i == gcl_pkg::ADDR_ST1) begin
      rd_data[8:0]                  = {q.ls_err_flag, q.hs_err_flag, q.desat_flag}; // RULE20
      rd_data[gcl_pkg::ST1_SD]       = q.shutdown;
      rd_data[gcl_pkg::ST1_SIM]      = q.sim_en;
      rd_data[gcl_pkg::ST1_SIM_USED] = q.sim_used;
      rd_data[gcl_pkg::ST1_EN]       = q.en;
    end else if (paddr_i == gcl_pkg::ADDR_CMD) begin
      rd_data = '0;
    end else if (paddr_i == gcl_pkg::ADDR_SIM) begin
      rd_data[0] = q.sim_en;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin : top_next
    d      = q;
    setup  = psel_i && !penable_i;
    wr_acc = psel_i && penable_i && q.pready && pwrite_i && !q.pslverr;
    clr0   = wr_acc && (paddr_i == gcl_pkg::ADDR_CMD) && (pwdata_i[7:0] == gcl_pkg::CMD_CLR0);
    clr1   = wr_acc && (paddr_i == gcl_pkg::ADDR_CMD) && (pwdata_i[7:0] == gcl_pkg::CMD_CLR1);
    // apb answer, no wait state
    d.pready  = setup;
    d.pslverr = setup && !rd_hit;
    if (setup) begin
      d.prdata = rd_data; // RULE7
    end
    // register writes
    if (wr_acc) begin
      if (paddr_i == gcl_pkg::ADDR_CTRL) begin
        if (!q.ctrl[gcl_pkg::CTRL_LOCK]) begin
          d.ctrl = pwdata_i[gcl_pkg::CTRL_W-1:0]; // RULE5
        end
      end else if (paddr_i == gcl_pkg::ADDR_DT) begin
        if (pwdata_i[gcl_pkg::SET_W-1:0] > gcl_pkg::DT_SET_MAX || pwdata_i[31:8] != '0) begin
          d.dt_set = gcl_pkg::DT_SET_MAX; // RULE1
        end else begin
          d.dt_set = pwdata_i[gcl_pkg::SET_W-1:0]; // RULE1
        end
      end else if (paddr_i == gcl_pkg::ADDR_CAL) begin
        d.cal = pwdata_i[gcl_pkg::CAL_W-1:0]; // RULE2
      end else if (paddr_i == gcl_pkg::ADDR_MASK) begin
        d.mask = pwdata_i[2:0]; // RULE6 RULE21
      end else if (paddr_i == gcl_pkg::ADDR_CMD) begin
        if (pwdata_i[7:0] == gcl_pkg::CMD_KEY_A) begin
          d.guard = gcl_pkg::GD_KEY_A; // RULE4
        end else if (pwdata_i[7:0] == gcl_pkg::CMD_KEY_B && q.guard == gcl_pkg::GD_KEY_A) begin
          d.guard = gcl_pkg::GD_OPEN; // RULE4
        end else begin
          d.guard = gcl_pkg::GD_IDLE;
        end
      end else if (paddr_i == gcl_pkg::ADDR_SIM) begin
        d.guard = gcl_pkg::GD_IDLE;
        if (q.guard == gcl_pkg::GD_OPEN && !q.sim_used) begin
          d.sim_en   = pwdata_i[0]; // RULE4 RULE3
          d.sim_used = 1'b1; // RULE4
        end
      end
    end
    // fault latching: set wins over clear, clear only once absent
    d.oc_ind  = overcurrent_cmp_i; // RULE13
    d.oc_flag = overcurrent_cmp_i || (q.oc_flag && !clr0); // RULE13 RULE26
    for (int i = 0; i < gcl_pkg::NPH; i++) begin
      d.desat_flag[i]  = desat_fault[i] || (q.desat_flag[i] && !(clr1 && !desat_start[i])); // RULE18 RULE20 RULE26
      d.hs_err_flag[i] = hs_err[i] || (q.hs_err_flag[i] && !clr1); // RULE20 RULE24 RULE26
      d.ls_err_flag[i] = ls_err[i] || (q.ls_err_flag[i] && !clr1); // RULE24 RULE26
    end
    // shutdown on desaturation and phase faults unless disabled
    d.shutdown = !q.ctrl[gcl_pkg::CTRL_NO_SD] && (|d.desat_flag || |d.hs_err_flag ||
                 |d.ls_err_flag); // RULE18 RULE21
    d.en       = enable_input_one_i && enable_input_two_i && !d.shutdown; // RULE23
    // interrupt from masked status
    d.irq = |({|d.hs_err_flag || |d.ls_err_flag, |d.desat_flag, d.oc_flag} & q.mask); // RULE15 RULE16 RULE6
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin : top_reg
    if (!rst_n_i) begin
      q          <= '0; // RULE22
      q.ctrl     <= gcl_pkg::CTRL_RST;
      q.dt_set   <= gcl_pkg::DT_SET_RST;
      q.cal      <= gcl_pkg::CAL_RST;
      q.mask     <= gcl_pkg::MASK_RST;
      q.guard    <= gcl_pkg::GD_IDLE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign prdata_o                       = q.prdata;
  assign pready_o                       = q.pready;
  assign pslverr_o                      = q.pslverr;
  assign overcurrent_indicator_output_o = q.oc_ind;
  assign int_o                          = q.irq;
endmodule : gcl_top
`default_nettype wire

// File: test/gcl_stage_model.sv
/* gcl_stage_model: power stage behind the gates, feeding the comparators.
   assumes gate outputs of gcl_top; short_i forces a short to ground. */
`timescale 1ns/10ps
`default_nettype none
module gcl_stage_model (
  // gates and fault
  input  wire logic [2:0] hs_g_i,
  input  wire logic       short_i,
  // comparators
  output var  logic [2:0] desat_o,
  output var  logic [2:0] phase_o
);
  // ========================================
  // source node follows the high side
  assign phase_o = hs_g_i;
  assign desat_o = short_i ? hs_g_i : 3'h0;
endmodule : gcl_stage_model
`default_nettype wire

// File: test/gcl_props.sv
/* gcl_props: port checks of gcl_top.
   assumes one clock domain; bound from the testbench. */
`timescale 1ns/10ps
`default_nettype none
module gcl_props (
  // clock, reset, apb
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic       pready_o,
  // pins
  input wire logic       enable_input_one_i,
  input wire logic       enable_input_two_i,
  input wire logic       overcurrent_cmp_i,
  input wire logic       overcurrent_indicator_output_o,
  input wire logic [2:0] high_side_command_input_i,
  input wire logic [2:0] high_side_gate_output_o,
  input wire logic [2:0] low_side_gate_output_o
);
  // ========================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_no_shoot_through:
    assert property ((high_side_gate_output_o & low_side_gate_output_o) == 3'h0)
    else $error("both gates on");
  a_oc_indicator:
    assert property ($past(rst_n_i) |-> overcurrent_indicator_output_o == $past(overcurrent_cmp_i))
    else $error("indicator off cause");
  a_ready_next:
    assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_access:
    assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  a_ready_single:
    assert property (pready_o |=> !pready_o)
    else $error("ready too long");
  a_disabled_off:
    assert property ((!(enable_input_one_i && enable_input_two_i))[*2]
      |=> (high_side_gate_output_o | low_side_gate_output_o) == 3'h0)
    else $error("gate on while disabled");
  a_ls_drops_first:
    assert property ($rose(high_side_command_input_i[0]) |-> ##[0:2] !low_side_gate_output_o[0])
    else $error("low gate kept on");
  a_hs_has_cause:
    assert property ($rose(high_side_gate_output_o[0])
      |-> $past(high_side_command_input_i[0]) && !$past(low_side_gate_output_o[0]))
    else $error("high gate on without cause");
endmodule : gcl_props
`default_nettype wire

// File: test/testbench.sv
/* testbench: drives gcl_top over APB and its phase pins.
   assumes gcl_pkg, gcl_top, gcl_stage_model and gcl_props compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ========================================
  // signals
  logic        clk = 0, rst_n = 0, sel = 0, ena = 0, wr = 0, en = 0, oc = 0, sh = 0;
  logic        rdy, err, oci, irq, er;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0, prd, rd;
  logic [2:0]  hc = 3'h0, lc = 3'h0, hg, lg, blk, dc, pc;
  int          fail_count = 0, n_compared = 0, n;
  always #2 clk = ~clk;
  gcl_stage_model u_stage (.hs_g_i(hg), .short_i(sh), .desat_o(dc), .phase_o(pc));
  gcl_top DUT (.clk_i(clk), .rst_n_i(rst_n), .paddr_i(adr), .psel_i(sel),
    .penable_i(ena), .pwrite_i(wr), .pwdata_i(wd), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .enable_input_one_i(en), .enable_input_two_i(en),
    .high_side_command_input_i(hc), .low_side_command_input_i(lc),
    .high_side_source_node_desat_i(dc), .high_side_source_node_phase_i(pc),
    .overcurrent_cmp_i(oc), .high_side_gate_output_o(hg), .low_side_gate_output_o(lg),
    .current_limit_blank_o(blk), .overcurrent_indicator_output_o(oci), .int_o(irq));
  // ========================================
  // shared tasks
  task report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    sel <= 1'h1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    ena <= 1'h1;
    do begin
      @(posedge clk);
      i++;
    end while (rdy !== 1'h1 && i < 20);
    rd = prd;
    er = err;
    sel <= 1'h0;
    ena <= 1'h0;
    if (i == 20) begin
      fail_count++;
      report_and_stop();
    end
  endtask : apb
  task wait_gate(input logic low, input logic lvl);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((low ? lg[0] : hg[0]) !== lvl && n < 900);
    if (n == 900) begin
      fail_count++;
      report_and_stop();
    end
  endtask : wait_gate
  // ========================================
  // scenarios
  task t_regs;
    apb(1'h0, gcl_pkg::ADDR_CAL, 32'h0);
    chk(rd, 32'(gcl_pkg::DT_STEP_CYC));
    apb(1'h1, gcl_pkg::ADDR_CTRL, 32'h8);
    apb(1'h1, gcl_pkg::ADDR_CTRL, 32'h1);
    apb(1'h0, gcl_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h8);
    apb(1'h1, gcl_pkg::ADDR_DT, 32'hFF);
    apb(1'h0, gcl_pkg::ADDR_DT, 32'h0);
    chk(rd, 32'(gcl_pkg::DT_SET_MAXV));
    apb(1'h0, 12'h020, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("test regs done");
  endtask : t_regs
  task t_gate;
    apb(1'h1, gcl_pkg::ADDR_DT, 32'h1);
    en <= 1'h1;
    repeat (4) @(posedge clk);
    hc <= 3'h1;
    repeat (30) @(posedge clk);
    chk(32'(hg[0]), 32'h0);
    hc <= 3'h0;
    repeat (30) @(posedge clk);
    lc <= 3'h1;
    wait_gate(1'h1, 1'h1);
    chk(32'(n), 32'h2);
    repeat (20) @(posedge clk);
    hc <= 3'h1;
    wait_gate(1'h0, 1'h1);
    chk(32'(n), 32'(gcl_pkg::DT_STEP_CYC + 2));
    chk(32'(blk[0]), 32'h1);
    $display("test gate done");
  endtask : t_gate
  task t_desat;
    @(posedge clk);
    sh <= 1'h1;
    wait_gate(1'h0, 1'h0);
    chk(32'(n > 250 && n < 400 && lg == 3'h0), 32'h1);
    apb(1'h0, gcl_pkg::ADDR_ST0, 32'h0);
    chk(rd, 32'h2);
    $display("test desat done");
  endtask : t_desat
  task t_oc;
    apb(1'h1, gcl_pkg::ADDR_MASK, 32'h1);
    oc <= 1'h1;
    repeat (3) @(posedge clk);
    oc <= 1'h0;
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    apb(1'h0, gcl_pkg::ADDR_ST0, 32'h0);
    chk(32'(rd[0]), 32'h1);
    apb(1'h1, gcl_pkg::ADDR_CMD, 32'(gcl_pkg::CMD_CLR0));
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    apb(1'h1, gcl_pkg::ADDR_CMD, 32'(gcl_pkg::CMD_CLR1));
    apb(1'h0, gcl_pkg::ADDR_ST0, 32'h0);
    chk(rd, 32'h0);
    $display("test oc done");
  endtask : t_oc
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_gate();
    t_desat();
    t_oc();
    report_and_stop();
  end
endmodule : testbench
bind gcl_top gcl_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .enable_input_one_i(enable_input_one_i),
  .enable_input_two_i(enable_input_two_i), .overcurrent_cmp_i(overcurrent_cmp_i),
  .overcurrent_indicator_output_o(overcurrent_indicator_output_o),
  .high_side_command_input_i(high_side_command_input_i),
  .high_side_gate_output_o(high_side_gate_output_o),
  .low_side_gate_output_o(low_side_gate_output_o));
`default_nettype wire
